// [rtl/asp_defines.svh]
// Constants of the asynchronous serial data path: offsets, fields, resets.
// Assumes inclusion by bare name from the top module.
// Notes on behaviour
// - Receiver timed by 16x receive clock input.
// - Shift serial input, move character to buffer.
// - New buffered character raises enabled receive interrupt.
// - Reading receive buffer clears receive interrupt.
// - Free 8-bit scratch register, no side effects.
// - Transmitter timed by internal baud clock.
// - Holding moves to shifter only when idle.
// - Shifter serialises character onto serial output.
// - Empty holding register raises enabled interrupt.
// - Writing holding register clears its interrupt.
// - Framing for both sections from line control.
// - Baud clock is reference divided by divisor.
// - Divisor write reloads the baud counter.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ASP_OFS_DATA    8'h00
`define ASP_OFS_LINE    8'h04
`define ASP_OFS_DIV     8'h08
`define ASP_OFS_SCRATCH 8'h0C
`define ASP_OFS_STATUS  8'h10
`define ASP_OFS_IRQ     8'h14
`define ASP_OFS_MASK    8'h18

// ==========================================================
// Field positions
`define ASP_LINE_PAR_EN   2
`define ASP_LINE_EVEN     3
`define ASP_LINE_STOP2    4
`define ASP_IRQ_RX        0
`define ASP_IRQ_TXE       1

// ==========================================================
// Reset values and timing
`define ASP_LINE_RST      5'h03
`define ASP_DIV_RST       16'h0001
`define ASP_OVS           5'h10
`define ASP_HALF          5'h08
`define ASP_STOP15        6'h18

`endif

// [rtl/asp_pkg.sv]
// Types shared by the asynchronous serial data path.
// Assumes the defines header sits on the include path.
`default_nettype none
package asp_pkg;
    // Shared framing states of both shifters
    typedef enum logic [2:0] {
        ASP_IDLE,
        ASP_START,
        ASP_DATA,
        ASP_PAR,
        ASP_STOP
    } asp_state_t;
endpackage
`default_nettype wire

// [rtl/asp_serial_path.sv]
// Serial data path: APB register slave, baud generator, receiver, transmitter.
// Assumes a 40 MHz clk_i; receive clock and serial input are asynchronous pins.
//
// Chosen here: the APB slave port and the register addresses.
`include "asp_defines.svh"
`default_nettype none
module asp_serial_path
    import asp_pkg::*;
#(
    parameter int DIV_W = 16                 // Divisor width
) (
    input  wire logic        clk_i,          // System clock
    input  wire logic        resetn_i,       // Synchronous reset, active low
    input  wire logic        psel_i,         // APB select
    input  wire logic        penable_i,      // APB access phase
    input  wire logic        pwrite_i,       // APB direction
    input  wire logic [7:0]  paddr_i,        // APB byte address
    input  wire logic [31:0] pwdata_i,       // APB write data
    output logic      [31:0] prdata_o,       // APB read data
    output logic             pready_o,       // APB ready
    output logic             pslverr_o,      // APB error on unmapped address
    input  wire logic        rx_clock_i,     // 16x receive clock pin
    input  wire logic        serial_in_i,    // Serial input pin
    output logic             serial_out_o,   // Serial output pin
    output logic             baud_clock_out_o, // Baud tick, one cycle per period
    output logic             irq_o           // Level interrupt
);

    // ==========================================================
    // Elaboration check
    if (DIV_W != 16) begin : g_bad
        $error("asp_serial_path supports a 16-bit divisor only");
    end

    // ==========================================================
    // State record
    typedef struct packed {
        logic [31:0]      prdata;    // Read data register
        logic             pready;    // Ready register
        logic             pslverr;   // Error register
        logic [4:0]       line;      // Framing: len, parity, even, stop2
        logic [15:0]      div;       // Divisor latch
        logic [15:0]      bcnt;      // Baud counter
        logic             btick;     // Baud tick
        logic [7:0]       scratch;   // Scratchpad byte
        logic [1:0]       ists;      // Sticky interrupt status
        logic [1:0]       mask;      // Interrupt enables
        logic             irq;       // Interrupt output
        logic [2:0]       rck_s;     // Receive clock synchroniser
        logic             rck_f;     // Filtered receive clock
        logic [2:0]       sin_s;     // Serial input synchroniser
        logic             sin_f;     // Filtered serial input
        asp_state_t       rst;       // Receiver state
        logic [4:0]       rtk;       // Receiver tick count
        logic [2:0]       rbit;      // Receiver bit count
        logic [7:0]       rsh;       // Receiver shift register
        logic [7:0]       rbuf;      // Receive buffer
        logic             rdy;       // Receive buffer full
        asp_state_t       tst;       // Transmitter state
        logic [5:0]       ttk;       // Transmitter tick count
        logic [2:0]       tbit;      // Transmitter bit count
        logic [7:0]       tsh;       // Transmit shift register
        logic             tpar;      // Running transmit parity
        logic [7:0]       thold;     // Holding register
        logic             tempty;    // Holding register empty
        logic             serial_out;      // Serial output
    } asp_regs_t;

    asp_regs_t r_r;                  // Registered state
    asp_regs_t r_nxt;                // Next state

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic       acc;             // Access phase, first cycle
        logic       done;            // Transfer completes this edge
        logic       wr;              // Completing write
        logic       rd_data;         // Completing read of receive buffer
        logic       wr_data;         // Completing write of holding register
        logic       rtick;           // Receive 16x tick
        logic [2:0] nbits;           // Data bits minus one
        logic       set_rx;          // Receive event
        logic       set_txe;         // Holding went empty
        logic [31:0] rdv;            // Read mux value
        logic       hit;             // Address mapped
        r_nxt   = r_r;
        acc     = psel_i & penable_i & ~r_r.pready;
        done    = psel_i & penable_i & r_r.pready;
        wr      = done & pwrite_i;
        rd_data = done & ~pwrite_i & (paddr_i == `ASP_OFS_DATA);
        wr_data = wr & (paddr_i == `ASP_OFS_DATA);
        nbits   = {1'b1, r_r.line[1:0]};
        set_rx  = 1'b0;
        set_txe = 1'b0;
        rdv     = 32'h0000_0000;
        hit     = 1'b1;
        rtick   = 1'b0;

        // Bus answer: one wait state, data captured with ready
        unique case (paddr_i)
            `ASP_OFS_DATA:    rdv = {24'h00_0000, r_r.rbuf};
            `ASP_OFS_LINE:    rdv = {27'h000_0000, r_r.line};
            `ASP_OFS_DIV:     rdv = {16'h0000, r_r.div};
            `ASP_OFS_SCRATCH: rdv = {24'h00_0000, r_r.scratch};
            `ASP_OFS_STATUS:  rdv = {29'h0000_0000, (r_r.tst == ASP_IDLE), r_r.tempty, r_r.rdy};
            `ASP_OFS_IRQ:     rdv = {30'h0000_0000, r_r.ists};
            `ASP_OFS_MASK:    rdv = {30'h0000_0000, r_r.mask};
            default: begin
                hit = 1'b0;  // Unmapped: error, reads zero
            end
        endcase
        r_nxt.pready  = acc;
        r_nxt.pslverr = acc & ~hit;
        r_nxt.prdata  = acc ? rdv : 32'h0000_0000;

        // Register writes land at the completing edge
        if (wr) begin
            unique case (paddr_i)
                `ASP_OFS_LINE:    r_nxt.line = pwdata_i[4:0];
                `ASP_OFS_DIV: begin
                    r_nxt.div  = pwdata_i[15:0];
                    r_nxt.bcnt = pwdata_i[15:0];
                end
                `ASP_OFS_SCRATCH: r_nxt.scratch = pwdata_i[7:0];
                `ASP_OFS_MASK:    r_nxt.mask = pwdata_i[1:0];
                default: begin
                end
            endcase
        end

        // Baud generator; divisor zero holds the tick low
        r_nxt.btick = 1'b0;
        if (!(wr && paddr_i == `ASP_OFS_DIV) && r_r.div != 16'h0000) begin
            if (r_r.bcnt <= 16'h0001) begin
                r_nxt.bcnt  = r_r.div;
                r_nxt.btick = 1'b1;
            end else begin
                r_nxt.bcnt = r_r.bcnt - 16'h0001;
            end
        end

        // Pin synchronisers: a change counts once stages two and three agree
        r_nxt.rck_s = {r_r.rck_s[1:0], rx_clock_i};
        if (r_r.rck_s[1] == r_r.rck_s[2]) begin
            r_nxt.rck_f = r_r.rck_s[2];
        end
        r_nxt.sin_s = {r_r.sin_s[1:0], serial_in_i};
        if (r_r.sin_s[1] == r_r.sin_s[2]) begin
            r_nxt.sin_f = r_r.sin_s[2];
        end
        rtick = r_nxt.rck_f & ~r_r.rck_f;

        // Receiver; samples bit centres at sixteen ticks per bit
        if (rtick) begin
            r_nxt.rtk = r_r.rtk + 5'h01;
            unique case (r_r.rst)
                ASP_IDLE: begin
                    r_nxt.rtk = 5'h00;
                    if (!r_r.sin_f) begin
                        r_nxt.rst = ASP_START;
                    end
                end
                ASP_START: begin
                    if (r_r.rtk == `ASP_HALF - 5'h02) begin
                        r_nxt.rtk  = 5'h00;
                        r_nxt.rbit = 3'h0;
                        // False start: line back high at mid bit
                        r_nxt.rst  = r_r.sin_f ? ASP_IDLE : ASP_DATA;
                    end
                end
                ASP_DATA: begin
                    if (r_r.rtk == `ASP_OVS - 5'h01) begin
                        r_nxt.rtk = 5'h00;
                        r_nxt.rsh = {r_r.sin_f, r_r.rsh[7:1]};
                        r_nxt.rbit = r_r.rbit + 3'h1;
                        if (r_r.rbit == nbits) begin
                            r_nxt.rst = r_r.line[`ASP_LINE_PAR_EN] ? ASP_PAR : ASP_STOP;
                        end
                    end
                end
                ASP_PAR: begin
                    if (r_r.rtk == `ASP_OVS - 5'h01) begin
                        r_nxt.rtk = 5'h00;
                        r_nxt.rst = ASP_STOP;
                    end
                end
                ASP_STOP: begin
                    if (r_r.rtk == `ASP_OVS - 5'h01) begin
                        r_nxt.rst  = ASP_IDLE;
                        // Right-align short characters
                        r_nxt.rbuf = r_r.rsh >> (3'h7 - nbits);
                        r_nxt.rdy  = 1'b1;
                        set_rx     = 1'b1;
                    end
                end
                default: r_nxt.rst = ASP_IDLE;
            endcase
        end
        if (rd_data && !set_rx) begin
            r_nxt.rdy = 1'b0;
        end

        // Holding register load from the bus
        if (wr_data) begin
            r_nxt.thold  = pwdata_i[7:0];
            r_nxt.tempty = 1'b0;
        end

        // Transmitter on baud ticks
        if (r_r.btick) begin
            r_nxt.ttk = r_r.ttk + 6'h01;
            unique case (r_r.tst)
                ASP_IDLE: begin
                    r_nxt.ttk = 6'h00;
                    if (!r_r.tempty) begin
                        r_nxt.tsh    = r_r.thold;
                        r_nxt.tpar   = ~r_r.line[`ASP_LINE_EVEN];
                        // A write at this same edge keeps the new character held
                        r_nxt.tempty = ~wr_data;
                        set_txe      = 1'b1;
                        r_nxt.serial_out   = 1'b0;
                        r_nxt.tst    = ASP_START;
                    end
                end
                ASP_START, ASP_DATA: begin
                    if (r_r.ttk == 6'h0F) begin
                        r_nxt.ttk = 6'h00;
                        if (r_r.tst == ASP_START) begin
                            r_nxt.tbit = 3'h0;
                            r_nxt.tst  = ASP_DATA;
                        end else begin
                            r_nxt.tbit = r_r.tbit + 3'h1;
                            r_nxt.tsh  = {1'b0, r_r.tsh[7:1]};
                            r_nxt.tpar = r_r.tpar ^ r_r.tsh[0];
                        end
                        r_nxt.serial_out = r_nxt.tsh[0];
                        if (r_r.tst == ASP_DATA && r_r.tbit == nbits) begin
                            r_nxt.tst  = r_r.line[`ASP_LINE_PAR_EN] ? ASP_PAR : ASP_STOP;
                            r_nxt.serial_out = r_r.line[`ASP_LINE_PAR_EN] ?
                                         (r_r.tpar ^ r_r.tsh[0]) : 1'b1;
                        end
                    end
                end
                ASP_PAR: begin
                    if (r_r.ttk == 6'h0F) begin
                        r_nxt.ttk  = 6'h00;
                        r_nxt.serial_out = 1'b1;
                        r_nxt.tst  = ASP_STOP;
                    end
                end
                ASP_STOP: begin
                    // One, one and a half or two stop bits
                    if (r_r.ttk == (!r_r.line[`ASP_LINE_STOP2] ? 6'h0F :
                                    (r_r.line[1:0] == 2'b00) ? `ASP_STOP15 - 6'h01 :
                                    6'h1F)) begin
                        r_nxt.tst = ASP_IDLE;
                    end
                end
                default: r_nxt.tst = ASP_IDLE;
            endcase
        end

        // Sticky interrupt status, write one to clear, set wins
        if (wr && paddr_i == `ASP_OFS_IRQ) begin
            r_nxt.ists = r_r.ists & ~pwdata_i[1:0];
        end
        if (rd_data) begin
            r_nxt.ists[`ASP_IRQ_RX] = 1'b0;
        end
        if (wr_data) begin
            r_nxt.ists[`ASP_IRQ_TXE] = 1'b0;
        end
        if (set_rx) begin
            r_nxt.ists[`ASP_IRQ_RX] = 1'b1;
        end
        if (set_txe) begin
            r_nxt.ists[`ASP_IRQ_TXE] = 1'b1;
        end
        r_nxt.irq = |(r_nxt.ists & r_nxt.mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            r_r        <= '0;
            r_r.line   <= `ASP_LINE_RST;
            r_r.div    <= `ASP_DIV_RST;
            r_r.bcnt   <= `ASP_DIV_RST;
            r_r.rck_s  <= 3'h0;
            r_r.sin_s  <= 3'h7;
            r_r.sin_f  <= 1'b1;
            r_r.rst    <= ASP_IDLE;
            r_r.tst    <= ASP_IDLE;
            r_r.tempty <= 1'b1;
            r_r.serial_out   <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign prdata_o         = r_r.prdata;
    assign pready_o         = r_r.pready;
    assign pslverr_o        = r_r.pslverr;
    assign serial_out_o     = r_r.serial_out;
    assign baud_clock_out_o = r_r.btick;
    assign irq_o            = r_r.irq;

endmodule
`default_nettype wire

// [tb/asp_link_model.sv]
// Far end of the serial link: frames characters onto the receive pins.
// Assumes calls only between frames, from just after a clk_i rising edge.
`default_nettype none
module asp_link_model (
    input  wire logic clk_i,      // System clock, paces the ticks
    output logic      rx_clock_o, // 16x clock, still between frames
    output logic      serial_o    // Serial line, idle high
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Idle line
    initial begin
        rx_clock_o = 1'b0;
        serial_o   = 1'b1;
    end
    // One bit: sixteen ticks, each edge held four cycles so sync sees it
    task automatic bit_out(input logic b);
        serial_o <= b;
        repeat (16) begin
            repeat (4) @(posedge clk_i);
            rx_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx_clock_o <= 1'b0;
        end
    endtask
    // Start, n data bits LSB first, parity p[0] when p[1], one stop
    task automatic send(input logic [7:0] c, input int n, input logic [1:0] p);
        bit_out(1'b0);
        for (int i = 0; i < n; i++) begin
            bit_out(c[i]);
        end
        if (p[1]) begin
            bit_out(p[0]);
        end
        bit_out(1'b1);
    endtask
endmodule
`default_nettype wire

// [tb/asp_serial_path_props.sv]
// Checker of the serial data path: bus timing, errors, scratch, irq, line.
// Assumes a divisor of one whenever a frame runs on the serial output.
`default_nettype none
module asp_serial_path_props #(
    parameter int DIV_W = 16 // Divisor width, kept for the bind
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        serial_out_o,
    input wire logic        irq_o
);
    // ==========================================================
    // Helpers
    logic       done;     // Transfer completes at this edge
    logic [7:0] scr_r;    // Last scratch value written
    logic       scr_ok_r; // Scratch known since reset
    logic [1:0] msk_r;    // Copy of the mask register
    assign done = psel_i && penable_i && pready_o;
    // Follow writes at the edge they take effect
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            scr_ok_r <= 1'b0;
            msk_r    <= 2'h0;
        end else if (done && pwrite_i && paddr_i == 8'h0C) begin
            scr_r    <= pwdata_i[7:0];
            scr_ok_r <= 1'b1;
        end else if (done && pwrite_i && paddr_i == 8'h18) begin
            msk_r <= pwdata_i[1:0];
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_data_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside ready cycle");
    a_err_unmapped: assert property (done && paddr_i > 8'h18 |-> pslverr_o)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (done && paddr_i inside {8'h00, 8'h04, 8'h08,
        8'h0C, 8'h10, 8'h14, 8'h18} |-> !pslverr_o)
        else $error("error on mapped address");
    a_scratch_back: assert property (done && !pwrite_i && paddr_i == 8'h0C && scr_ok_r
        |-> prdata_o == {24'h0, scr_r})
        else $error("scratch read differs from write");
    a_low_run: assert property ($fell(serial_out_o)
        |-> !serial_out_o [*8] ##1 !serial_out_o [*8])
        else $error("serial low run shorter than a bit");
    a_rx_clear: assert property (done && !pwrite_i && paddr_i == 8'h00 && msk_r == 2'h1
        |-> ##[1:2] !irq_o)
        else $error("receive read left irq high");
    a_irq_masked: assert property (msk_r == 2'h0 [*3] |-> !irq_o)
        else $error("irq high with mask clear");
    c_err: cover property (done && pslverr_o);
    c_frame: cover property ($fell(serial_out_o));
    c_irq: cover property ($rose(irq_o));
endmodule
bind asp_serial_path asp_serial_path_props #(.DIV_W(DIV_W)) asp_serial_path_props_i (
    .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .serial_out_o, .irq_o);
`default_nettype wire

// [tb/asp_serial_path_tb_top.sv]
// Bench of the serial data path: register rows, baud, transmit, receive, irq.
// Assumes the link model on the receive pins and the bound checker.
`default_nettype none
module asp_serial_path_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Signals
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd_v, n;
    logic        pready_o, pslverr_o, rx_clock_i, serial_in_i, er_v;
    logic        serial_out_o, baud_clock_out_o, irq_o;
    int          failures = 0;
    int          checks_done = 0;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} asp_row_t;
    // Write, then read back: address, data, readback, error
    asp_row_t rows [6] = '{'{8'h0C, 32'h000000A5, 32'h000000A5, 1'b0},
        '{8'h0C, 32'hFFFFFF5A, 32'h0000005A, 1'b0}, '{8'h04, 32'h0000001F, 32'h0000001F, 1'b0},
        '{8'h1C, 32'h12345678, 32'h0, 1'b1}, '{8'h18, 32'h0000FFFC, 32'h0, 1'b0},
        '{8'h08, 32'h0003FFFF, 32'h0000FFFF, 1'b0}};
    asp_serial_path asp_serial_path_i (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_clock_i, .serial_in_i,
        .serial_out_o, .baud_clock_out_o, .irq_o);
    asp_link_model asp_link_model_i (.clk_i, .rx_clock_o(rx_clock_i), .serial_o(serial_in_i));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // ==========================================================
    // Tasks
    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk32(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk1(input string s, input logic e, input logic g);
        chk32(s, {31'h0, e}, {31'h0, g});
    endtask
    task automatic hang(input string s);
        failures++;
        $display("MISMATCH %s expected done seen timeout", s);
        report_and_stop();
    endtask
    // One transfer after an idle edge; held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 16);
        rd_v = prdata_o;
        er_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) hang("pready");
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk32(s, e, rd_v);
    endtask
    // Count baud ticks over 20 cycles after a divisor write
    task automatic ticks(input logic [31:0] dv, input logic [31:0] e);
        apb(1'b1, 8'h08, dv);
        n = 32'h0;
        // Skip the edge after the reload: its tick is suppressed
        @(posedge clk_i);
        repeat (20) begin
            @(posedge clk_i);
            n = n + baud_clock_out_o;
        end
        chk32("baud ticks", e, n);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq_o !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 400) hang("irq");
    endtask
    // Decode one frame mid-bit, sixteen cycles a bit at divisor one
    task automatic tx_frame(input logic [7:0] c, input int w, input logic p, input logic odd);
        int k;
        k = 0;
        while (serial_out_o !== 1'b0 && k < 2000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 2000) hang("start bit");
        repeat (8) @(posedge clk_i);
        chk1("start", 1'b0, serial_out_o);
        for (int i = 0; i < w; i++) begin
            repeat (16) @(posedge clk_i);
            chk1("data bit", c[i], serial_out_o);
        end
        if (p) begin
            repeat (16) @(posedge clk_i);
            chk1("parity", ^c ^ odd, serial_out_o);
        end
        repeat (16) @(posedge clk_i);
        chk1("stop", 1'b1, serial_out_o);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        chk1("serial idle", 1'b1, serial_out_o);
        chk1("irq reset", 1'b0, irq_o);
        rdchk(8'h04, 32'h00000003, "line reset");
        rdchk(8'h08, 32'h00000001, "div reset");
        rdchk(8'h10, 32'h00000006, "status reset");
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk32("row data", rows[i].q, rd_v);
            chk1("row error", rows[i].e, er_v);
        end
        $display("test rows done");
        ticks(32'h00000005, 32'h00000004);
        ticks(32'h00000001, 32'h00000014);
        $display("test baud done");
        apb(1'b1, 8'h04, 32'h0000000F);
        fork
            begin
                tx_frame(8'hA6, 8, 1'b1, 1'b0);
                tx_frame(8'h3D, 8, 1'b1, 1'b0);
            end
            begin
                apb(1'b1, 8'h00, 32'h000000A6);
                rdchk(8'h14, 32'h00000002, "txe set");
                chk1("irq masked", 1'b0, irq_o);
                apb(1'b1, 8'h18, 32'h00000002);
                repeat (2) @(posedge clk_i);
                chk1("irq txe", 1'b1, irq_o);
                apb(1'b1, 8'h00, 32'h0000003D);
                rdchk(8'h14, 32'h0, "txe cleared");
                rdchk(8'h10, 32'h0, "holding full");
            end
        join
        apb(1'b1, 8'h18, 32'h0);
        repeat (2) @(posedge clk_i);
        chk1("irq off", 1'b0, irq_o);
        apb(1'b1, 8'h14, 32'h00000003);
        rdchk(8'h14, 32'h0, "irq w1c");
        // Seven bits, odd parity, two stop bits
        apb(1'b1, 8'h04, 32'h00000016);
        apb(1'b1, 8'h00, 32'h00000035);
        tx_frame(8'h35, 7, 1'b1, 1'b1);
        $display("test transmit done");
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h18, 32'h00000001);
        asp_link_model_i.send(8'h15, 5, 2'b00);
        wait_irq();
        rdchk(8'h10, 32'h00000007, "rx ready");
        rdchk(8'h00, 32'h00000015, "rx char");
        repeat (2) @(posedge clk_i);
        chk1("irq rx clear", 1'b0, irq_o);
        asp_link_model_i.send(8'h0A, 5, 2'b00);
        asp_link_model_i.send(8'h13, 5, 2'b00);
        wait_irq();
        rdchk(8'h00, 32'h00000013, "rx overwrite");
        rdchk(8'h10, 32'h00000006, "rx drained");
        // Eight bits with a parity bit on the line
        apb(1'b1, 8'h04, 32'h00000007);
        asp_link_model_i.send(8'hC3, 8, 2'b11);
        wait_irq();
        rdchk(8'h00, 32'h000000C3, "rx parity frame");
        rdchk(8'h0C, 32'h0000005A, "scratch kept");
        $display("test receive done");
        // Reset in mid-run: framing and mask return to reset values
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        chk1("irq after reset", 1'b0, irq_o);
        chk1("serial after reset", 1'b1, serial_out_o);
        rdchk(8'h04, 32'h00000003, "line after reset");
        rdchk(8'h18, 32'h0, "mask after reset");
        rdchk(8'h10, 32'h00000006, "status after reset");
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
